// [pkg/wdrf_defs.svh]
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDRF_DEFS_SVH
`define WDRF_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define WDRF_OFS_CTRL 8'h00
`define WDRF_OFS_FLAGS 8'h04
`define WDRF_OFS_EVT 8'h08
`define WDRF_OFS_MASK 8'h0c
`define WDRF_OFS_STAT 8'h10

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define WDRF_CTRL_RST 8'h53
`define WDRF_KEY_ENA_A 5'h0a
`define WDRF_KEY_ENA_B 5'h15
`define WDRF_FLAGS_KEYF 0
`define WDRF_FLAGS_UVF 2
`define WDRF_EVT_OVF 0
`define WDRF_EVT_KEY 1
`define WDRF_EVT_UV 2
`define WDRF_EVT_W 3
`define WDRF_STAT_TO 0
`define WDRF_STAT_ENA 1
`define WDRF_STAT_PEND 2
`define WDRF_CNT_W 18

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDRF_CLK_PERIOD_NS 50
`define WDRF_KEY_RESET_DELAY_NS 1000
`define WDRF_UV_QUALIFY_NS 60000
`define WDRF_KEY_RESET_CYCLES ((`WDRF_KEY_RESET_DELAY_NS + `WDRF_CLK_PERIOD_NS - 1) / `WDRF_CLK_PERIOD_NS)
`define WDRF_UV_QUALIFY_CYCLES ((`WDRF_UV_QUALIFY_NS + `WDRF_CLK_PERIOD_NS - 1) / `WDRF_CLK_PERIOD_NS)

`endif

// [pkg/wdrf_pkg.sv]
// Types shared by the watchdog block
package wdrf_pkg;

	// APB request from the master
	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} wdrf_apb_req_t;

	// Key reset sequencer states
	typedef enum logic [2:0]
	{
		KEY_ARMED = 3'b001,
		KEY_DELAY = 3'b010,
		KEY_FIRE = 3'b100
	} wdrf_key_state_t;

endpackage

// [rtl/wdrf_sync.sv]
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module wdrf_sync #(
	parameter int WIDTH = 1 // Number of bits
)(
	input wire logic clk, // Clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [WIDTH-1:0] din, // Asynchronous inputs
	output logic [WIDTH-1:0] dout // Synchronised outputs
);

	logic [WIDTH-1:0] meta_ff; // First stage, read only by second

	// ----------------------------------------
	// Two flops in series
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= '0;
			dout <= '0;
		end
		else
		begin
			meta_ff <= din;
			dout <= meta_ff;
		end
	end

endmodule

// [rtl/wdrf_watchdog.sv]
// Watchdog timer with reset-source flags and APB register slave
//
// Behaviour
// RULE_01: Counter clocked by slow RC, power-two divide
// RULE_02: Selector picks 2^8..2^18 divide ratio
// RULE_03: Enabled only for keys 01010 or 10101
// RULE_04: Bad key: delayed full reset, flag set
// RULE_05: Power-on key 01010, selector 011
// RULE_06: Counter cleared by bad key, clear, halt
// RULE_07: Software clears watchdog before timeout
// RULE_08: Overflow when running: full reset, timeout flag
// RULE_09: Overflow asleep: timeout flag, clear PC/SP
// RULE_10: Key-reset flag set by hardware, software clears
// RULE_11: Undervoltage flag set on reset, software clears
// RULE_12: Undervoltage reset only after qualification time
// RULE_13: Undervoltage reset disabled in sleep/idle
// RULE_14: Power-on reset clears program counter
// RULE_15: Power-on reset presets ports to ones
// RULE_16: Unused reset-flag bits read zero
// RULE_17: Overflow asleep also wakes the core
// RULE_18: Overflow one-cycle pulse; counter runs asleep
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "wdrf_defs.svh"
module wdrf_watchdog #(
	parameter int KEY_RESET_CYCLES = `WDRF_KEY_RESET_CYCLES, // Key reset delay
	parameter int UV_QUALIFY_CYCLES = `WDRF_UV_QUALIFY_CYCLES // Low-supply qualify
)(
	input wire logic pclk, // Bus clock, 20 MHz
	input wire logic presetn, // Power-on reset, active low
	input wire wdrf_pkg::wdrf_apb_req_t apb_req, // APB request
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped
	input wire logic slow_rc_clock, // Slow RC oscillator pin
	input wire logic low_supply, // Supply below threshold
	input wire logic sleep_idle, // Core in sleep or idle
	input wire logic clear_watchdog_instruction, // Clear instruction pulse
	input wire logic halt_instr, // Halt instruction pulse
	output logic device_reset, // Full reset pulse
	output logic pc_sp_clear, // Clear PC and stack pointer
	output logic port_preset, // Preset ports to ones
	output logic wake_up, // Wake-up pulse
	output logic timeout_status_flag, // Timeout status
	output logic irq // Level interrupt
);
	import wdrf_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [1:0] pin_sync; // Synchronised pins
	logic rc_prev_ff; // Previous slow clock level
	logic [7:0] ctrl_ff; // watchdog_control
	logic [7:0] nxt_ctrl; // Next control value
	logic [`WDRF_CNT_W-1:0] cnt_ff; // Watchdog counter
	logic [`WDRF_CNT_W-1:0] nxt_cnt; // Next counter
	wdrf_key_state_t key_state_ff; // Key sequencer state
	wdrf_key_state_t nxt_key_state; // Next key state
	logic [15:0] key_cnt_ff; // Key delay counter
	logic [15:0] nxt_key_cnt; // Next key delay
	logic [15:0] uv_cnt_ff; // Low-supply counter
	logic [15:0] nxt_uv_cnt; // Next low-supply count
	logic uv_done_ff; // Low-supply reset already fired
	logic key_flag_ff; // key_reset_flag
	logic uv_flag_ff; // undervoltage_reset_flag
	logic to_ff; // timeout_status_flag
	logic [`WDRF_EVT_W-1:0] evt_ff; // Sticky event status
	logic [`WDRF_EVT_W-1:0] nxt_evt; // Next event status
	logic [`WDRF_EVT_W-1:0] mask_ff; // Event mask
	logic [31:0] prdata_ff; // Read data register
	logic pready_ff; // Ready register
	logic pslverr_ff; // Error register
	logic device_reset_ff; // Full reset output
	logic pc_sp_clear_ff; // PC/SP clear output
	logic port_preset_ff; // Port preset output
	logic wake_up_ff; // Wake-up output
	logic irq_ff; // Interrupt output

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wdrf_sync #(
		.WIDTH(2)
	) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.din({low_supply, slow_rc_clock}),
		.dout(pin_sync)
	);

	// ----------------------------------------
	// Decode and selection
	// ----------------------------------------
	wire rc_sync = pin_sync[0]; // Slow clock level
	wire uv_low = pin_sync[1]; // Low supply level
	// RULE_01 slow clock edge
	wire slow_tick = rc_sync & ~rc_prev_ff;
	wire [4:0] key = ctrl_ff[7:3]; // wdt_key_field
	wire [2:0] tsel = ctrl_ff[2:0]; // timeout_select
	// RULE_03 enabling keys
	wire key_ok = (key == `WDRF_KEY_ENA_A) || (key == `WDRF_KEY_ENA_B);
	wire setup = apb_req.psel & ~apb_req.penable; // Setup phase
	wire access = apb_req.psel & apb_req.penable & pready_ff; // Completion
	wire wr = access & apb_req.pwrite; // Write completes
	wire rd = access & ~apb_req.pwrite; // Read completes
	wire hit_ctrl = apb_req.paddr == `WDRF_OFS_CTRL; // Control hit
	wire hit_flags = apb_req.paddr == `WDRF_OFS_FLAGS; // Flags hit
	wire hit_evt = apb_req.paddr == `WDRF_OFS_EVT; // Event hit
	wire hit_mask = apb_req.paddr == `WDRF_OFS_MASK; // Mask hit
	wire hit_stat = apb_req.paddr == `WDRF_OFS_STAT; // Status hit
	wire mapped = hit_ctrl | hit_flags | hit_evt | hit_mask | hit_stat;
	wire wr_ctrl = wr & hit_ctrl; // Control write
	wire [4:0] wkey = apb_req.pwdata[7:3]; // Written key
	// RULE_06 bad key write clears counter
	wire bad_key_wr = wr_ctrl & ~((wkey == `WDRF_KEY_ENA_A) || (wkey == `WDRF_KEY_ENA_B));

	// RULE_02 divide ratio mask
	function automatic logic [`WDRF_CNT_W-1:0] div_mask(input logic [2:0] s);
		logic [`WDRF_CNT_W-1:0] m;
		m = '0;
		case (s)
			3'h0: m = 18'h000ff;
			3'h1: m = 18'h003ff;
			3'h2: m = 18'h00fff;
			3'h3: m = 18'h03fff;
			3'h4: m = 18'h07fff;
			3'h5: m = 18'h0ffff;
			3'h6: m = 18'h1ffff;
			default: m = 18'h3ffff;
		endcase
		return m;
	endfunction

	wire [`WDRF_CNT_W-1:0] mask_sel = div_mask(tsel); // Selected ratio
	// RULE_18 single-cycle carry out
	wire ovf = slow_tick & key_ok & ((cnt_ff & mask_sel) == mask_sel);
	// RULE_08 overflow while running
	wire ovf_run = ovf & ~sleep_idle;
	// RULE_09 overflow while asleep
	wire ovf_sleep = ovf & sleep_idle;
	// RULE_04 fixed-delay key reset fires
	wire key_fire = key_state_ff == KEY_FIRE;
	// RULE_12 qualified low supply
	wire uv_fire = uv_low & ~sleep_idle & ~uv_done_ff & (uv_cnt_ff == UV_QUALIFY_CYCLES[15:0]);
	wire full_rst = ovf_run | key_fire | uv_fire; // Any full reset
	wire [`WDRF_EVT_W-1:0] evt_set = {uv_fire, key_fire, ovf}; // Event sources

	// RULE_16 unused flag bits zero
	wire [31:0] flags_word = (32'(uv_flag_ff) << `WDRF_FLAGS_UVF) | (32'(key_flag_ff) << `WDRF_FLAGS_KEYF);
	wire [31:0] stat_word = (32'(to_ff) << `WDRF_STAT_TO) | (32'(key_ok) << `WDRF_STAT_ENA)
		| (32'(key_state_ff != KEY_ARMED) << `WDRF_STAT_PEND);
	wire [31:0] rdata_mux = hit_ctrl ? {24'h000000, ctrl_ff} :
		hit_flags ? flags_word :
		hit_evt ? {29'h00000000, evt_ff} :
		hit_mask ? {29'h00000000, mask_ff} :
		hit_stat ? stat_word : 32'h00000000;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// Control register: a full reset reloads defaults
	// RULE_05 default key and selector
	assign nxt_ctrl = full_rst ? `WDRF_CTRL_RST : (wr_ctrl ? apb_req.pwdata[7:0] : ctrl_ff);

	// Counter: clears win, otherwise counts slow ticks
	always_comb
	begin
		nxt_cnt = cnt_ff;
		// RULE_06 the three clear causes plus a full reset
		if (bad_key_wr || clear_watchdog_instruction || halt_instr || full_rst)
		begin
			nxt_cnt = '0;
		end
		// RULE_18 runs also in sleep and idle
		else if (ovf)
		begin
			nxt_cnt = '0;
		end
		// RULE_01 count divided slow clock
		else if (slow_tick && key_ok)
		begin
			nxt_cnt = cnt_ff + 18'h00001;
		end
	end

	// Key sequencer: bad key waits the delay then fires
	always_comb
	begin
		nxt_key_state = key_state_ff;
		nxt_key_cnt = key_cnt_ff;
		case (key_state_ff)
			KEY_ARMED:
			begin
				// RULE_03 any other key requests reset
				if (!key_ok)
				begin
					nxt_key_state = KEY_DELAY;
					nxt_key_cnt = KEY_RESET_CYCLES[15:0];
				end
			end
			KEY_DELAY:
			begin
				// RULE_04 fixed delay runs out
				if (key_cnt_ff <= 16'h0001)
				begin
					nxt_key_state = KEY_FIRE;
					nxt_key_cnt = 16'h0000;
				end
				else
				begin
					nxt_key_cnt = key_cnt_ff - 16'h0001;
				end
			end
			KEY_FIRE:
			begin
				// Control reloaded by the same reset on this edge
				nxt_key_state = KEY_ARMED;
			end
			default:
			begin
				nxt_key_state = KEY_ARMED;
				nxt_key_cnt = 16'h0000;
			end
		endcase
	end

	// Low-supply qualification counter
	always_comb
	begin
		nxt_uv_cnt = 16'h0000;
		// RULE_13 inactive in sleep and idle
		if (uv_low && !sleep_idle && !uv_done_ff && !uv_fire)
		begin
			nxt_uv_cnt = uv_cnt_ff + 16'h0001;
		end
	end

	// Sticky events: set wins over read clear
	assign nxt_evt = evt_set | ((rd && hit_evt) ? {`WDRF_EVT_W{1'b0}} : evt_ff);

	// ----------------------------------------
	// Timer and sequencer registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rc_prev_ff <= 1'b0;
			ctrl_ff <= `WDRF_CTRL_RST;
			cnt_ff <= '0;
			key_state_ff <= KEY_ARMED;
			key_cnt_ff <= 16'h0000;
			uv_cnt_ff <= 16'h0000;
			uv_done_ff <= 1'b0;
		end
		else
		begin
			rc_prev_ff <= rc_sync;
			ctrl_ff <= nxt_ctrl;
			cnt_ff <= nxt_cnt;
			key_state_ff <= nxt_key_state;
			key_cnt_ff <= nxt_key_cnt;
			uv_cnt_ff <= nxt_uv_cnt;
			// One undervoltage reset per low episode
			uv_done_ff <= uv_low & (uv_done_ff | uv_fire);
		end
	end

	// ----------------------------------------
	// Reset-source flags
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			key_flag_ff <= 1'b0;
			uv_flag_ff <= 1'b0;
			to_ff <= 1'b0;
		end
		else
		begin
			// RULE_10 hardware set wins over write
			key_flag_ff <= key_fire | ((wr && hit_flags) ? apb_req.pwdata[`WDRF_FLAGS_KEYF] : key_flag_ff);
			// RULE_11 set on undervoltage reset
			uv_flag_ff <= uv_fire | ((wr && hit_flags) ? apb_req.pwdata[`WDRF_FLAGS_UVF] : uv_flag_ff);
			// RULE_08 timeout flag on overflow
			to_ff <= ovf | (to_ff & ~clear_watchdog_instruction & ~halt_instr);
		end
	end

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			evt_ff <= '0;
			mask_ff <= '0;
			irq_ff <= 1'b0;
		end
		else
		begin
			evt_ff <= nxt_evt;
			if (wr && hit_mask)
			begin
				mask_ff <= apb_req.pwdata[`WDRF_EVT_W-1:0];
			end
			irq_ff <= |(evt_ff & mask_ff);
		end
	end

	// ----------------------------------------
	// APB answer, zero wait states
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff <= 32'h00000000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~mapped;
			// Read data latched in setup phase
			prdata_ff <= (setup && !apb_req.pwrite) ? rdata_mux : 32'h00000000;
		end
	end

	// ----------------------------------------
	// Reset and wake outputs
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			device_reset_ff <= 1'b0;
			// RULE_14 PC cleared on power-on
			pc_sp_clear_ff <= 1'b1;
			// RULE_15 ports preset on power-on
			port_preset_ff <= 1'b1;
			wake_up_ff <= 1'b0;
		end
		else
		begin
			// RULE_08 full reset on overflow
			device_reset_ff <= full_rst;
			// RULE_09 only PC and SP when asleep
			pc_sp_clear_ff <= ovf_sleep;
			port_preset_ff <= 1'b0;
			// RULE_17 overflow asleep wakes core
			wake_up_ff <= ovf_sleep;
		end
	end

	// ----------------------------------------
	// Output wiring
	// ----------------------------------------
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign device_reset = device_reset_ff;
	assign pc_sp_clear = pc_sp_clear_ff;
	assign port_preset = port_preset_ff;
	assign wake_up = wake_up_ff;
	assign timeout_status_flag = to_ff;
	assign irq = irq_ff;

endmodule

// [sim/wdrf_watchdog_monitor.sv]
// Port checker for the watchdog block
`timescale 1ns/1ps
module wdrf_monitor
	import wdrf_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire wdrf_apb_req_t apb_req, // Bus request
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic device_reset, // Reset pulse
	input wire logic pc_sp_clear, // PC clear
	input wire logic port_preset, // Port preset
	input wire logic wake_up, // Wake pulse
	input wire logic timeout_status_flag // Timeout flag
);
	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_setup: assert property (apb_req.psel && !apb_req.penable |=> pready)
		else $error("ready missing after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	// ----------------------------------------
	// Watchdog outputs
	// ----------------------------------------
	a_reset_pulse: assert property (device_reset |=> !device_reset)
		else $error("reset pulse too long");
	a_wake_pulse: assert property (wake_up |=> !wake_up)
		else $error("wake pulse too long");
	a_wake_sleep: assert property (wake_up |-> pc_sp_clear && timeout_status_flag && !device_reset)
		else $error("sleep overflow outputs wrong");
	a_flag_cause: assert property ($rose(timeout_status_flag) |-> device_reset || wake_up)
		else $error("timeout flag without overflow");
	a_por_outputs: assert property ($rose(presetn) |-> pc_sp_clear && port_preset)
		else $error("power-on outputs not set");
	a_preset_low: assert property ($past(presetn) |-> !port_preset)
		else $error("port preset after reset");
endmodule

// [sim/watchdog_and_reset_flags_test.sv]
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module watchdog_and_reset_flags_test;
	import wdrf_pkg::*;
	localparam int KEY_CYC = 3; // Short key reset delay
	localparam int UV_CYC = 5; // Short low-supply qualify
	logic pclk = 1'b0, presetn = 1'b0, slow = 1'b0, low = 1'b0;
	logic sleep = 1'b0, clr = 1'b0, halt = 1'b0;
	wdrf_apb_req_t req = '0; // Bus request
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, dev_rst, pcsp, preset, wake, tflag, irq;
	int n_fail = 0, comparisons = 0, n_rst = 0, n_wake = 0;
	// ----------------------------------------
	// Clock, design and pulse counters
	// ----------------------------------------
	initial forever #25 pclk = ~pclk;
	wdrf_watchdog #(.KEY_RESET_CYCLES(KEY_CYC), .UV_QUALIFY_CYCLES(UV_CYC)) uut (.pclk(pclk),
		.presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.slow_rc_clock(slow), .low_supply(low), .sleep_idle(sleep), .clear_watchdog_instruction(clr),
		.halt_instr(halt), .device_reset(dev_rst), .pc_sp_clear(pcsp), .port_preset(preset),
		.wake_up(wake), .timeout_status_flag(tflag), .irq(irq));
	// Count reset and wake pulses
	always @(posedge pclk)
	begin
		if (dev_rst === 1'b1) n_rst++;
		if (wake === 1'b1) n_wake++;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One transfer; result in rd and er
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		req <= '0;
		if (i == 20)
		begin
			n_fail++;
			end_sim();
		end
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	// Slow clock rising edges, eight bus cycles each
	task ticks(input int n);
		repeat (n)
		begin
			@(posedge pclk) slow <= 1'b1;
			cyc(4);
			slow <= 1'b0;
			cyc(3);
		end
	endtask
	// Halt or clear instruction pulse
	task instr(input logic h);
		@(posedge pclk);
		if (h) halt <= 1'b1; else clr <= 1'b1;
		@(posedge pclk);
		halt <= 1'b0;
		clr <= 1'b0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset();
		int c;
		rchk(8'h00, 32'h53);
		rchk(8'h04, 32'h0);
		rchk(8'h14, 32'h0);
		`CHK(er, 1'b1)
		for (c = 0; c < 8; c++)
		begin
			apb(1'b1, 8'h00, {24'h0, 5'h15, c[2:0]});
			rchk(8'h00, {24'h0, 5'h15, c[2:0]});
		end
		rchk(8'h10, 32'h2);
	endtask
	// Awake overflow at two ratios, then interrupt
	task t_ovf();
		int s, r0;
		apb(1'b1, 8'h0c, 32'h0);
		for (s = 0; s < 2; s++)
		begin
			apb(1'b1, 8'h00, {24'h0, 5'h0a, s[2:0]});
			instr(1'b0);
			r0 = n_rst;
			ticks((s == 0) ? 255 : 1023);
			`CHK(n_rst, r0)
			ticks(1);
			cyc(4);
			`CHK(n_rst, r0 + 1)
			`CHK(tflag, 1'b1)
			rchk(8'h00, 32'h53);
		end
		rchk(8'h10, 32'h3);
		`CHK(irq, 1'b0)
		apb(1'b1, 8'h0c, 32'h1);
		cyc(2);
		`CHK(irq, 1'b1)
		rchk(8'h08, 32'h1);
		cyc(2);
		`CHK(irq, 1'b0)
	endtask
	// Halt and clear restart the count
	task t_clear();
		int r0;
		apb(1'b1, 8'h00, 32'h50);
		instr(1'b0);
		r0 = n_rst;
		ticks(200);
		instr(1'b1);
		`CHK(tflag, 1'b0)
		ticks(200);
		instr(1'b0);
		ticks(200);
		cyc(4);
		`CHK(n_rst, r0)
	endtask
	// Overflow asleep wakes; low supply ignored
	task t_sleep();
		int r0, w0;
		sleep <= 1'b1;
		instr(1'b0);
		r0 = n_rst;
		w0 = n_wake;
		ticks(256);
		cyc(4);
		`CHK(n_wake, w0 + 1)
		`CHK(n_rst, r0)
		`CHK(tflag, 1'b1)
		low <= 1'b1;
		cyc(30);
		low <= 1'b0;
		cyc(4);
		`CHK(n_rst, r0)
		sleep <= 1'b0;
		instr(1'b0);
	endtask
	// Bad key: pulse after delay plus sequencer latency
	task t_key();
		int i;
		apb(1'b1, 8'h00, 32'h0);
		for (i = 0; i < 40 && dev_rst !== 1'b1; i++) @(posedge pclk);
		`CHK(i, KEY_CYC + 3)
		if (i == 40) end_sim();
		rchk(8'h04, 32'h1);
		rchk(8'h00, 32'h53);
		apb(1'b1, 8'h04, 32'hffffffff);
		rchk(8'h04, 32'h5);
		apb(1'b1, 8'h04, 32'h0);
		rchk(8'h04, 32'h0);
	endtask
	task t_uv();
		int r0;
		r0 = n_rst;
		low <= 1'b1;
		cyc(2);
		low <= 1'b0;
		cyc(12);
		`CHK(n_rst, r0)
		low <= 1'b1;
		cyc(30);
		low <= 1'b0;
		cyc(6);
		`CHK(n_rst, r0 + 1)
		rchk(8'h04, 32'h4);
		apb(1'b1, 8'h04, 32'h0);
		rchk(8'h04, 32'h0);
	endtask
	// Main sequence
	initial
	begin
		cyc(20);
		`CHK(pcsp, 1'b1)
		`CHK(preset, 1'b1)
		presetn <= 1'b1;
		t_reset();
		t_ovf();
		t_clear();
		t_sleep();
		t_key();
		t_uv();
		end_sim();
	end
endmodule
bind wdrf_watchdog wdrf_monitor mon (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .device_reset(device_reset),
	.pc_sp_clear(pc_sp_clear), .port_preset(port_preset), .wake_up(wake_up),
	.timeout_status_flag(timeout_status_flag));
